// [rtl/hcr_defines.svh]
// constants of the host control and failed-write register slice
`ifndef HCR_DEFINES_SVH
`define HCR_DEFINES_SVH
`define HCR_OFS_ERR_LOW 8'h38
`define HCR_OFS_ERR_HIGH 8'h3c
`define HCR_OFS_MAKER 8'h40
`define HCR_OFS_FLAGS_SET 8'h50
`define HCR_OFS_FLAGS_CLR 8'h54
`define HCR_ADDR_W 8
`define HCR_BUS_LSB 22
`define HCR_NODE_LSB 16
`define HCR_OFFHI_LSB 0
`define HCR_BIB_VALID_BIT 31
`define HCR_SOFT_RESET_BIT 16
`define HCR_SET_MASK 32'he04f0000
`define HCR_CLR_MASK 32'h604f0000
`define HCR_FIXED_ONES 32'h00800000
`define HCR_FLAGS_RESET 32'h00800000
`define HCR_ERR_RESET 32'h00000000
`endif

// [rtl/hcr_err_capture.sv]
// capture store for the details of a failed posted write
`timescale 1ns/100ps
`include "hcr_defines.svh"
module hcr_err_capture
  import hcr_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic errStrobe, // one-cycle pulse: posted write failed
  input wire logic [47:0] errOffset, // destination offset of failed write
  input wire logic [15:0] errRequester, // bus and node of requester
  output hcr_pkg::hcr_word_t errLow, // captured low offset word
  output hcr_pkg::hcr_word_t errHigh // captured requester and high offset
);
  import hcr_pkg::*;

  hcr_err_s st;
  hcr_err_s stNext;

  // only the failure strobe updates the store; the bus cannot write it
  always_comb
  begin
    stNext = st;
    if (errStrobe)
    begin
      stNext.errLow = errOffset[31:0];
      stNext.errHigh = {errRequester, errOffset[47:32]};
    end
  end

  // contents are meaningless until a capture; zero is as good as any
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st.errLow <= `HCR_ERR_RESET;
      st.errHigh <= `HCR_ERR_RESET;
    end
    else
    begin
      st <= stNext;
    end
  end

  assign errLow = st.errLow;
  assign errHigh = st.errHigh;
endmodule

// [rtl/hcr_host_regs.sv]
// ahb-lite register slice: failed-write capture, identity, control flags
`timescale 1ns/100ps
`include "hcr_defines.svh"
module hcr_host_regs
  import hcr_pkg::*;
#(
  parameter hcr_pkg::hcr_word_t MAKER_ID = 32'h5a5a0001 // arbitrary value
)
(
  input wire logic mclk, // system clock, 10 MHz
  input wire logic sys_rst, // async reset, active high
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data, data phase
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data, registered
  output logic hreadyout, // slave ready, registered
  output logic hresp, // response, always okay
  input wire logic errStrobe, // pulse: posted write failed
  input wire logic [47:0] errOffset, // destination offset of failure
  input wire logic [15:0] errRequester, // bus number and node number
  input wire logic bibFetchErr, // pulse: hardware drops bit 31
  input wire logic softResetDone, // pulse: hardware drops bit 16 unless a same-cycle set writes it
  output logic [31:0] ctrlFlags // current control flags, registered
);
  import hcr_pkg::*;

  hcr_regs_s st;
  hcr_regs_s stNext;
  hcr_word_t errLow;
  hcr_word_t errHigh;
  hcr_word_t flagsView;
  logic addrPhase;

  // the capture store is kept apart so the bus path can never write it
  hcr_err_capture uCapture
  (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .errStrobe(errStrobe),
    .errOffset(errOffset),
    .errRequester(errRequester),
    .errLow(errLow),
    .errHigh(errHigh)
  );

  // a transfer is taken when selected, nonseq/seq, and the bus is ready
  assign addrPhase = hsel && htrans[1] && hready;

  // next state: data-phase write, hardware updates, address-phase read
  always_comb
  begin
    stNext = st;
    stNext.ready = 1'b1;
    stNext.resp = 1'b0;
    if (st.dpWrite)
    begin
      if (st.dpAddr == `HCR_OFS_FLAGS_SET)
        stNext.flags = st.flags | (hwdata & `HCR_SET_MASK);
      else if (st.dpAddr == `HCR_OFS_FLAGS_CLR)
        stNext.flags = st.flags & ~(hwdata & `HCR_CLR_MASK);
    end
    // hardware drops take effect after a same-cycle software write;
    // a software set of bit 16 in the same cycle still wins
    if (bibFetchErr)
      stNext.flags[`HCR_BIB_VALID_BIT] = 1'b0;
    if (softResetDone && !(st.dpWrite &&
        st.dpAddr == `HCR_OFS_FLAGS_SET &&
        hwdata[`HCR_SOFT_RESET_BIT]))
      stNext.flags[`HCR_SOFT_RESET_BIT] = 1'b0;
    stNext.dpWrite = addrPhase && hwrite;
    stNext.dpAddr = addrPhase ? haddr[7:0] : st.dpAddr;
    if (addrPhase && !hwrite)
    begin
      case (haddr[7:0])
        `HCR_OFS_ERR_LOW: stNext.rdata = errLow;
        `HCR_OFS_ERR_HIGH: stNext.rdata = errHigh;
        `HCR_OFS_MAKER: stNext.rdata = MAKER_ID;
        `HCR_OFS_FLAGS_SET: stNext.rdata = flagsView;
        `HCR_OFS_FLAGS_CLR: stNext.rdata = flagsView;
        default: stNext.rdata = 32'h00000000;
      endcase
    end
  end

  // reads forward the flags as updated by a write just finishing, so a
  // read right behind a write never returns stale flags
  assign flagsView = stNext.flags;

  // bit 23 is held in a flop set by reset; no mask ever touches it, so
  // the output stays a plain register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st.flags <= `HCR_FLAGS_RESET;
      st.rdata <= 32'h00000000;
      st.ready <= 1'b1;
      st.resp <= 1'b0;
      st.dpWrite <= 1'b0;
      st.dpAddr <= 8'h00;
    end
    else
    begin
      st <= stNext;
    end
  end

  assign hrdata = st.rdata;
  assign hreadyout = st.ready;
  assign hresp = st.resp;
  assign ctrlFlags = st.flags;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // capture of a failure shows in both words one cycle later
  a_capture_both: assert property (errStrobe |=>
    (errLow == $past(errOffset[31:0])) &&
    (errHigh[15:0] == $past(errOffset[47:32])))
    else $error("failed write not captured");

  a_low_offset: assert property (errStrobe |=>
    errLow == $past(errOffset[31:0]))
    else $error("low offset word wrong");

  a_high_offset: assert property (errStrobe |=>
    errHigh[15:0] == $past(errOffset[47:32]))
    else $error("high offset bits wrong");

  a_requester_field: assert property (errStrobe |=>
    errHigh[31:22] == $past(errRequester[15:6]) &&
    errHigh[21:16] == $past(errRequester[5:0]))
    else $error("requester identity misplaced");

  a_error_hold: assert property (!errStrobe |=>
    $stable(errLow) && $stable(errHigh))
    else $error("error registers changed without a failure");

  a_maker_read: assert property (addrPhase && !hwrite &&
    haddr[7:0] == `HCR_OFS_MAKER |=> hrdata == MAKER_ID)
    else $error("identity read wrong");

  a_set_view: assert property (st.dpWrite &&
    st.dpAddr == `HCR_OFS_FLAGS_SET && !bibFetchErr && !softResetDone
    |=> (ctrlFlags & ($past(hwdata) & `HCR_SET_MASK)) ==
        ($past(hwdata) & `HCR_SET_MASK))
    else $error("set view failed to set flags");

  a_clear_view: assert property (st.dpWrite &&
    st.dpAddr == `HCR_OFS_FLAGS_CLR
    |=> (ctrlFlags & $past(hwdata) & `HCR_CLR_MASK) == 32'h00000000)
    else $error("clear view failed to clear flags");

  a_readonly_bits: assert property (
    (ctrlFlags & ~(`HCR_SET_MASK | `HCR_FIXED_ONES)) == 32'h00000000 &&
    ctrlFlags[23])
    else $error("read-only flag bits wrong");

  a_bib_drop: assert property (bibFetchErr |=>
    !ctrlFlags[`HCR_BIB_VALID_BIT])
    else $error("bit 31 not dropped by hardware");

  c_capture: cover property (errStrobe ##1 addrPhase && !hwrite &&
    haddr[7:0] == `HCR_OFS_ERR_HIGH);
  c_set_then_clear: cover property (st.dpWrite &&
    st.dpAddr == `HCR_OFS_FLAGS_SET ##[1:8] st.dpWrite &&
    st.dpAddr == `HCR_OFS_FLAGS_CLR);
  c_soft_reset: cover property (ctrlFlags[16] ##1 !ctrlFlags[16]);
  c_bib_drop: cover property (ctrlFlags[31] ##1 !ctrlFlags[31]);

  // the slave never stretches a transfer
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("slave ready dropped");

  // no error response exists in this slice
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");

  // a read at the strobe edge still sees the old capture
  a_err_low_read: assert property (addrPhase && !hwrite &&
    haddr[7:0] == `HCR_OFS_ERR_LOW |=> hrdata == $past(errLow))
    else $error("low error word read wrong");

  a_err_high_read: assert property (addrPhase && !hwrite &&
    haddr[7:0] == `HCR_OFS_ERR_HIGH |=> hrdata == $past(errHigh))
    else $error("high error word read wrong");

  // both views show the flags as they stand after the read edge
  a_set_read: assert property (addrPhase && !hwrite &&
    haddr[7:0] == `HCR_OFS_FLAGS_SET |=> hrdata == ctrlFlags)
    else $error("set view read wrong");

  a_clear_read: assert property (addrPhase && !hwrite &&
    haddr[7:0] == `HCR_OFS_FLAGS_CLR |=> hrdata == ctrlFlags)
    else $error("clear view read wrong");

  // holes in the map read as zero
  a_unmapped_read: assert property (addrPhase && !hwrite &&
    haddr[7:0] != `HCR_OFS_ERR_LOW && haddr[7:0] != `HCR_OFS_ERR_HIGH &&
    haddr[7:0] != `HCR_OFS_MAKER && haddr[7:0] != `HCR_OFS_FLAGS_SET &&
    haddr[7:0] != `HCR_OFS_FLAGS_CLR |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");

  // writes never disturb the read data register
  a_write_rdata: assert property (addrPhase && hwrite |=>
    $stable(hrdata))
    else $error("read data changed on a write");

  // software writes to the capture words are dropped
  a_err_write: assert property (st.dpWrite && !errStrobe &&
    (st.dpAddr == `HCR_OFS_ERR_LOW || st.dpAddr == `HCR_OFS_ERR_HIGH)
    |=> $stable(errLow) && $stable(errHigh))
    else $error("software reached the error words");

  // bit 31 leaves only through a fetch error or reset
  a_bit31_hold: assert property (ctrlFlags[31] && !bibFetchErr |=>
    ctrlFlags[31])
    else $error("bit 31 dropped without a fetch error");

  a_bit31_noclr: assert property (st.dpWrite &&
    st.dpAddr == `HCR_OFS_FLAGS_CLR && !bibFetchErr && ctrlFlags[31]
    |=> ctrlFlags[31])
    else $error("software cleared bit 31");

  // a soft reset completion drops bit 16 unless set in the same cycle
  a_soft_drop: assert property (softResetDone &&
    !(st.dpWrite && st.dpAddr == `HCR_OFS_FLAGS_SET && hwdata[16])
    |=> !ctrlFlags[16])
    else $error("bit 16 not dropped by hardware");

  a_soft_set_wins: assert property (softResetDone && st.dpWrite &&
    st.dpAddr == `HCR_OFS_FLAGS_SET && hwdata[16] |=> ctrlFlags[16])
    else $error("same-cycle set of bit 16 lost");

  a_fixed_bit: assert property (ctrlFlags[23])
    else $error("fixed flag bit not one");

  // zero bits written to a view leave their flags alone
  a_set_zero_bits: assert property (st.dpWrite &&
    st.dpAddr == `HCR_OFS_FLAGS_SET && !bibFetchErr && !softResetDone
    |=> ((ctrlFlags ^ $past(ctrlFlags)) & ~$past(hwdata)) ==
        32'h00000000)
    else $error("set view changed unwritten flags");

  a_clr_zero_bits: assert property (st.dpWrite &&
    st.dpAddr == `HCR_OFS_FLAGS_CLR && !bibFetchErr && !softResetDone
    |=> ((ctrlFlags ^ $past(ctrlFlags)) & ~$past(hwdata)) ==
        32'h00000000)
    else $error("clear view changed unwritten flags");

  // without a write or a hardware pulse the flags stand still
  a_flags_idle: assert property (!st.dpWrite && !bibFetchErr &&
    !softResetDone |=> $stable(ctrlFlags))
    else $error("flags changed with no cause");

  // writes elsewhere in the map never touch the flags
  a_other_write: assert property (st.dpWrite &&
    st.dpAddr != `HCR_OFS_FLAGS_SET && st.dpAddr != `HCR_OFS_FLAGS_CLR &&
    !bibFetchErr && !softResetDone |=> $stable(ctrlFlags))
    else $error("foreign write changed the flags");

  // the data phase follows the taken address phase directly
  a_dp_write: assert property (addrPhase && hwrite |=>
    st.dpWrite)
    else $error("write data phase missing");

  a_dp_addr: assert property (addrPhase |=>
    st.dpAddr == $past(haddr[7:0]))
    else $error("data phase address wrong");

  // a capture word only moves with a failure strobe
  a_low_stable: assert property (!errStrobe |=>
    $stable(errLow))
    else $error("low error word moved");

  a_high_stable: assert property (!errStrobe |=>
    $stable(errHigh))
    else $error("high error word moved");

  // requester bits come straight from the strobe cycle
  a_bus_field: assert property (errStrobe |=>
    errHigh[31:22] == $past(errRequester[15:6]))
    else $error("bus number misplaced");

  a_node_field: assert property (errStrobe |=>
    errHigh[21:16] == $past(errRequester[5:0]))
    else $error("node number misplaced");
endmodule

// [rtl/hcr_pkg.sv]
// types shared by the host control register slice
package hcr_pkg;
  typedef logic [31:0] hcr_word_t;
  typedef logic [7:0] hcr_addr_t;
  typedef struct packed
  {
    hcr_word_t errLow;
    hcr_word_t errHigh;
  } hcr_err_s;
  typedef struct packed
  {
    hcr_word_t flags;
    hcr_word_t rdata;
    logic ready;
    logic resp;
    logic dpWrite;
    hcr_addr_t dpAddr;
  } hcr_regs_s;
endpackage

// [test/hcr_host_regs_tb.sv]
// self-checking bench for the host control and failed-write registers
`timescale 1ns/100ps
`include "hcr_defines.svh"
`define CHK(g, e) check(g, e)
module hcr_host_regs_tb;
  import hcr_pkg::*;
  localparam hcr_word_t MID = 32'h0c0ffee1; // arbitrary identity value
  logic mclk = 1'b0, sysRst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ctrlFlags;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, errStrobe = 1'b0, bibErr = 1'b0, swDone = 1'b0;
  logic [47:0] errOffset = 48'h0;
  logic [15:0] errReq = 16'h0;
  hcr_word_t rd;
  int num_errors = 0, tests_run = 0;
  hcr_host_regs #(.MAKER_ID(MID)) dut (.mclk(mclk), .sys_rst(sysRst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .errStrobe(errStrobe),
    .errOffset(errOffset), .errRequester(errReq), .bibFetchErr(bibErr),
    .softResetDone(swDone), .ctrlFlags(ctrlFlags));
  // 10 MHz system clock
  always #50 mclk = ~mclk;
  task automatic results;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input hcr_word_t g, input hcr_word_t e);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one single word transfer; the wait is bounded in case ready never comes
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input hcr_word_t d, output hcr_word_t r);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    n = 0;
    do @(posedge mclk); while (hreadyout !== 1'b1 && ++n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1 && ++n < 50);
    r = hrdata;
    if (n >= 50)
    begin
      num_errors++;
      results();
    end
  endtask
  // read a register and compare it with the expected word
  task automatic rdchk(input logic [7:0] a, input hcr_word_t e);
    xfer(1'b0, a, 32'h0, rd);
    `CHK(rd, e);
    `CHK(hresp, 1'b0);
  endtask
  task automatic wr(input logic [7:0] a, input hcr_word_t d);
    xfer(1'b1, a, d, rd);
  endtask
  // one-cycle hardware pulse, driven just after an edge
  task automatic pulse(input int which);
    if (which == 0) errStrobe <= 1'b1; else if (which == 1) bibErr <= 1'b1;
    else swDone <= 1'b1;
    @(posedge mclk);
    errStrobe <= 1'b0;
    bibErr <= 1'b0;
    swDone <= 1'b0;
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    // reset state: only the fixed bit stands in both views
    rdchk(`HCR_OFS_FLAGS_SET, 32'h00800000);
    rdchk(`HCR_OFS_FLAGS_CLR, 32'h00800000);
    $display("test reset done");
    // identity word is fixed and ignores writes; unmapped reads give 0
    rdchk(`HCR_OFS_MAKER, MID);
    wr(`HCR_OFS_MAKER, ~MID);
    rdchk(`HCR_OFS_MAKER, MID);
    rdchk(8'h44, 32'h0);
    $display("test identity done");
    // capture of a failed posted write, then software cannot overwrite it
    errOffset <= 48'h1234_89ab_cdef;
    errReq <= {10'h2a5, 6'h1b};
    pulse(0);
    errOffset <= 48'h0;
    errReq <= 16'h0;
    rdchk(`HCR_OFS_ERR_LOW, 32'h89abcdef);
    rdchk(`HCR_OFS_ERR_HIGH, {10'h2a5, 6'h1b, 16'h1234});
    wr(`HCR_OFS_ERR_LOW, 32'hffffffff);
    wr(`HCR_OFS_ERR_HIGH, 32'h0);
    rdchk(`HCR_OFS_ERR_LOW, 32'h89abcdef);
    rdchk(`HCR_OFS_ERR_HIGH, {10'h2a5, 6'h1b, 16'h1234});
    $display("test capture done");
    // set every bit: only the settable ones take, bit 23 stays fixed
    wr(`HCR_OFS_FLAGS_SET, 32'hffffffff);
    rdchk(`HCR_OFS_FLAGS_CLR, 32'he0cf0000);
    `CHK(ctrlFlags, 32'he0cf0000);
    wr(`HCR_OFS_FLAGS_SET, 32'h0);
    rdchk(`HCR_OFS_FLAGS_SET, 32'he0cf0000);
    // hardware drops bit 31 and bit 16
    pulse(1);
    rdchk(`HCR_OFS_FLAGS_SET, 32'h60cf0000);
    pulse(2);
    rdchk(`HCR_OFS_FLAGS_SET, 32'h60ce0000);
    $display("test hardware update done");
    // clear view: bit 31 cannot be cleared by software
    wr(`HCR_OFS_FLAGS_SET, 32'h80010000);
    wr(`HCR_OFS_FLAGS_CLR, 32'h0);
    rdchk(`HCR_OFS_FLAGS_SET, 32'he0cf0000);
    wr(`HCR_OFS_FLAGS_CLR, 32'hffffffff);
    rdchk(`HCR_OFS_FLAGS_CLR, 32'h80800000);
    `CHK(ctrlFlags, 32'h80800000);
    $display("test clear done");
    results();
  end
endmodule
